/* File: memmap_pkg.sv */
/*
 Shared constants and carrier types of the address-space decoding block.
 Assumes a single core clock and an 8-bit special-function register bus.
*/
package memmap_pkg;

	// ------------------------------------------------------------------
	// Special-function addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] SFR_POINTER_LOW = 8'h82;
	localparam logic [7:0] SFR_POINTER_HIGH = 8'h83;
	localparam logic [7:0] SFR_POINTER_SELECTOR = 8'h92;
	localparam logic [7:0] SELECTOR_RESET = 8'h00;
	localparam logic [7:0] REGION_SPLIT = 8'h80;

	// ------------------------------------------------------------------
	// Memory sizes and boundaries
	// ------------------------------------------------------------------
	localparam logic [15:0] ONCHIP_CODE_LIMIT = 16'h2000;
	localparam int POINTER_COUNT = 8;
	localparam int SELECT_WIDTH = 3;
	localparam int SFR_REGISTER_COUNT = 81;
	localparam int SFR_BIT_COUNT = 128;
	localparam int RESET_SOURCE_COUNT = 3;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DIRECT,
		MODE_INDIRECT,
		MODE_STACK
	} access_mode_t;

	typedef enum logic [1:0] {
		REGION_LOWER_RAM,
		REGION_UPPER_RAM,
		REGION_SFR
	} region_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic valid;
		logic wide;
		logic use_reg_one;
		logic [7:0] reg_zero;
		logic [7:0] reg_one;
	} xdata_req_t;

endpackage

/* File: reset_sync.sv */
/*
 Combines the reset request sources and synchronises them to the core clock.
 Assumes each source is a high-active request level.
*/
module reset_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [memmap_pkg::RESET_SOURCE_COUNT-1:0] sources,
	output logic request
);

	logic stage1_r;
	logic stage1_nxt;
	logic stage2_r;
	logic stage2_nxt;

	always_comb begin
		stage1_nxt = |sources; // RULE_03
		stage2_nxt = stage1_r;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			stage1_r <= 1'b1;
			stage2_r <= 1'b1;
		end else begin
			stage1_r <= stage1_nxt;
			stage2_r <= stage2_nxt;
		end
	end

	assign request = stage2_r;

endmodule // reset_sync

/* File: memory_map_and_pointer_select.sv */
/*
 Address-space decoding: code fetch routing, eight data pointers with
 selector, external data address forming, internal region decode, the
 reset output and the four-bit analog/digital input port.
 Assumes the core issues SFR accesses, fetch addresses and external data
 requests synchronously to clk; pins are synchronous inputs.
*/
// Overview of operation
// RULE_01: Four input-only pins read digitally while also feeding the converter mux.
// RULE_02: Reset output drives low while the synchronized reset request is active.
// RULE_03: Reset request raised by external reset, watchdog or oscillator watchdog.
// RULE_04: Fetches below 2000H use on-chip or external code by access pin.
// RULE_05: Program space spans 64 Kbytes, 8 Kbyte optionally on chip.
// RULE_06: Eight 16-bit data pointers; instructions act on the selected one only.
// RULE_07: Selector register at SFR address 92H chooses the active pointer.
// RULE_08: External data space is 64 Kbytes; 16-bit address from selected pointer.
// RULE_09: 8-bit external data address may come from either indirect register.
// RULE_10: Internal memory: lower 128 banked RAM, upper 128 RAM, 128 SFR bytes.
// RULE_11: Overlapping regions are chosen by addressing mode, not address.
// RULE_12: Stack may sit anywhere in internal data memory.
// RULE_13: All registers but counter and banks live in the 81-entry SFR area.
// RULE_14: SFR area offers 128 directly addressable bits.
// RULE_15: Selected pointer appears as high byte 83H and low byte 82H.
// RULE_16: Selector low three bits index the pointer; reset selects pointer zero.
// RULE_17: Fetches at 2000H and above always go to external code memory.
module memory_map_and_pointer_select (
	input wire logic clk,
	input wire logic rstn,
	input wire memmap_pkg::sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic [15:0] fetch_addr,
	input wire logic external_access_select,
	output logic fetch_external,
	input wire memmap_pkg::xdata_req_t xdata_req,
	output logic [15:0] xdata_addr,
	output logic xdata_valid,
	input wire logic [7:0] int_addr,
	input wire memmap_pkg::access_mode_t int_mode,
	output memmap_pkg::region_t int_region,
	input wire logic [3:0] analog_digital_inputs,
	output logic [3:0] port_digital,
	output logic [3:0] analog_mux_upper,
	input wire logic ext_reset_req,
	input wire logic watchdog_req,
	input wire logic osc_watchdog_req,
	output logic reset_out_n
);

	// ------------------------------------------------------------------
	// Pointer storage and selector
	// ------------------------------------------------------------------
	logic [7:0] pointer_selector_r;
	logic [7:0] pointer_selector_nxt;
	logic [15:0] pointer_r [memmap_pkg::POINTER_COUNT];
	logic [15:0] pointer_nxt [memmap_pkg::POINTER_COUNT];
	logic [memmap_pkg::SELECT_WIDTH-1:0] sel;

	assign sel = pointer_selector_r[memmap_pkg::SELECT_WIDTH-1:0]; // RULE_16

	always_comb begin
		pointer_selector_nxt = pointer_selector_r;
		if (sfr_req.wr && sfr_req.addr == memmap_pkg::SFR_POINTER_SELECTOR) begin
			pointer_selector_nxt = sfr_req.wdata; // RULE_07
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < memmap_pkg::POINTER_COUNT; gi++) begin : g_ptr
			always_comb begin
				pointer_nxt[gi] = pointer_r[gi];
				if (sel == memmap_pkg::SELECT_WIDTH'(gi)) begin // RULE_06
					if (sfr_req.wr &&
						sfr_req.addr == memmap_pkg::SFR_POINTER_LOW) begin
						pointer_nxt[gi][7:0] = sfr_req.wdata; // RULE_15
					end
					if (sfr_req.wr &&
						sfr_req.addr == memmap_pkg::SFR_POINTER_HIGH) begin
						pointer_nxt[gi][15:8] = sfr_req.wdata; // RULE_15
					end
				end
			end

			always_ff @(posedge clk) begin
				if (!rstn) begin
					pointer_r[gi] <= 16'h0000;
				end else begin
					pointer_r[gi] <= pointer_nxt[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pointer_selector_r <= memmap_pkg::SELECTOR_RESET; // RULE_16
		end else begin
			pointer_selector_r <= pointer_selector_nxt;
		end
	end

	// ------------------------------------------------------------------
	// SFR read path
	// ------------------------------------------------------------------
	logic [7:0] sfr_rdata_r;
	logic [7:0] sfr_rdata_nxt;
	logic sfr_hit_r;
	logic sfr_hit_nxt;

	// Only this block's three registers answer; the remaining SFR space of
	// 81 registers and 128 bit addresses belongs to other units.
	always_comb begin
		sfr_rdata_nxt = 8'h00;
		sfr_hit_nxt = 1'b0;
		if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				memmap_pkg::SFR_POINTER_LOW: begin
					sfr_rdata_nxt = pointer_r[sel][7:0]; // RULE_15
					sfr_hit_nxt = 1'b1;
				end
				memmap_pkg::SFR_POINTER_HIGH: begin
					sfr_rdata_nxt = pointer_r[sel][15:8]; // RULE_15
					sfr_hit_nxt = 1'b1;
				end
				memmap_pkg::SFR_POINTER_SELECTOR: begin
					sfr_rdata_nxt = pointer_selector_r; // RULE_07
					sfr_hit_nxt = 1'b1;
				end
				default: begin
					sfr_rdata_nxt = 8'h00; // RULE_13 RULE_14
					sfr_hit_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sfr_rdata_r <= 8'h00;
			sfr_hit_r <= 1'b0;
		end else begin
			sfr_rdata_r <= sfr_rdata_nxt;
			sfr_hit_r <= sfr_hit_nxt;
		end
	end

	assign sfr_rdata = sfr_rdata_r;
	assign sfr_hit = sfr_hit_r;

	// ------------------------------------------------------------------
	// Code fetch routing and external data address
	// ------------------------------------------------------------------
	logic fetch_external_r;
	logic fetch_external_nxt;
	logic [15:0] xdata_addr_r;
	logic [15:0] xdata_addr_nxt;
	logic xdata_valid_r;
	logic xdata_valid_nxt;

	always_comb begin
		// A 16-bit fetch address already bounds the space to 64 Kbytes.
		if (fetch_addr < memmap_pkg::ONCHIP_CODE_LIMIT) begin // RULE_05
			fetch_external_nxt = external_access_select; // RULE_04
		end else begin
			fetch_external_nxt = 1'b1; // RULE_17
		end
		xdata_valid_nxt = xdata_req.valid;
		if (xdata_req.wide) begin
			xdata_addr_nxt = pointer_r[sel]; // RULE_08
		end else if (xdata_req.use_reg_one) begin
			xdata_addr_nxt = {8'h00, xdata_req.reg_one}; // RULE_09
		end else begin
			xdata_addr_nxt = {8'h00, xdata_req.reg_zero}; // RULE_09
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			fetch_external_r <= 1'b0;
			xdata_addr_r <= 16'h0000;
			xdata_valid_r <= 1'b0;
		end else begin
			fetch_external_r <= fetch_external_nxt;
			xdata_addr_r <= xdata_addr_nxt;
			xdata_valid_r <= xdata_valid_nxt;
		end
	end

	assign fetch_external = fetch_external_r;
	assign xdata_addr = xdata_addr_r;
	assign xdata_valid = xdata_valid_r;

	// ------------------------------------------------------------------
	// Internal data memory region decode
	// ------------------------------------------------------------------
	memmap_pkg::region_t int_region_r;
	memmap_pkg::region_t int_region_nxt;

	always_comb begin
		if (int_addr < memmap_pkg::REGION_SPLIT) begin
			int_region_nxt = memmap_pkg::REGION_LOWER_RAM; // RULE_10
		end else begin
			unique case (int_mode)
				memmap_pkg::MODE_DIRECT:
					int_region_nxt = memmap_pkg::REGION_SFR; // RULE_11
				memmap_pkg::MODE_INDIRECT:
					int_region_nxt = memmap_pkg::REGION_UPPER_RAM; // RULE_11
				memmap_pkg::MODE_STACK:
					int_region_nxt = memmap_pkg::REGION_UPPER_RAM; // RULE_12
				default:
					int_region_nxt = memmap_pkg::REGION_UPPER_RAM;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			int_region_r <= memmap_pkg::REGION_LOWER_RAM;
		end else begin
			int_region_r <= int_region_nxt;
		end
	end

	assign int_region = int_region_r;

	// ------------------------------------------------------------------
	// Input port and reset output
	// ------------------------------------------------------------------
	logic [3:0] port_r;
	logic [3:0] port_nxt;
	logic reset_out_n_r;
	logic reset_out_n_nxt;
	logic reset_request;

	reset_sync u_reset_sync (
		.clk(clk),
		.rstn(rstn),
		.sources({osc_watchdog_req, watchdog_req, ext_reset_req}), // RULE_03
		.request(reset_request)
	);

	always_comb begin
		port_nxt = analog_digital_inputs; // RULE_01
		reset_out_n_nxt = ~reset_request; // RULE_02
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			port_r <= 4'h0;
			reset_out_n_r <= 1'b0;
		end else begin
			port_r <= port_nxt;
			reset_out_n_r <= reset_out_n_nxt;
		end
	end

	assign port_digital = port_r;
	assign analog_mux_upper = port_r; // RULE_01
	assign reset_out_n = reset_out_n_r;

endmodule // memory_map_and_pointer_select

/* File: memory_map_and_pointer_select_checker.sv */
/* Assertion checker for the address decoding block, bound below.
 Assumes one clock and a synchronous active-low reset. */
module memory_map_and_pointer_select_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire memmap_pkg::sfr_req_t sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic [15:0] fetch_addr,
	input wire logic external_access_select,
	input wire logic fetch_external,
	input wire memmap_pkg::xdata_req_t xdata_req,
	input wire logic [15:0] xdata_addr,
	input wire logic xdata_valid,
	input wire logic [7:0] int_addr,
	input wire memmap_pkg::access_mode_t int_mode,
	input wire memmap_pkg::region_t int_region,
	input wire logic [3:0] analog_digital_inputs,
	input wire logic [3:0] port_digital,
	input wire logic [3:0] analog_mux_upper,
	input wire logic ext_reset_req,
	input wire logic watchdog_req,
	input wire logic osc_watchdog_req,
	input wire logic reset_out_n
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	fetch_route_a:
	assert property ($past(rstn) |-> fetch_external == ($past(fetch_addr)
		>= 16'h2000 || $past(external_access_select))) else $error("fetch");
	region_sel_a:
	assert property ($past(rstn) |-> int_region == (($past(int_addr) < 8'h80)
		? memmap_pkg::REGION_LOWER_RAM : ($past(int_mode) ==
		memmap_pkg::MODE_DIRECT) ? memmap_pkg::REGION_SFR
		: memmap_pkg::REGION_UPPER_RAM)) else $error("region");
	port_copy_a:
	assert property ($past(rstn) |-> port_digital == analog_mux_upper
		&& port_digital == $past(analog_digital_inputs)) else $error("port");
	xdata_valid_a:
	assert property ($past(rstn) |-> xdata_valid == $past(xdata_req.valid))
		else $error("xvalid");
	narrow_addr_a:
	assert property ($past(rstn) && $past(xdata_req.valid && !xdata_req.wide)
		|-> xdata_addr == {8'h00, $past(xdata_req.use_reg_one)
		? $past(xdata_req.reg_one) : $past(xdata_req.reg_zero)})
		else $error("narrow");
	reset_src_a:
	assert property (ext_reset_req || watchdog_req || osc_watchdog_req
		|-> ##[1:4] !reset_out_n) else $error("reset out");
	hit_decode_a:
	assert property ($past(rstn) |-> sfr_hit == ($past(sfr_req.rd) &&
		$past(sfr_req.addr) inside {8'h82, 8'h83, 8'h92})) else $error("hit");
	idle_zero_a:
	assert property ($past(rstn) && !sfr_hit |-> sfr_rdata == 8'h00)
		else $error("rdata");
	sel_back_a:
	assert property (sfr_req.wr && sfr_req.addr == 8'h92 ##1 !sfr_req.wr ##1
		sfr_req.rd && sfr_req.addr == 8'h92 |=> sfr_rdata ==
		$past(sfr_req.wdata, 3)) else $error("selector");
	cover property (fetch_external && !external_access_select);
	cover property (xdata_valid);
	cover property ($fell(reset_out_n));
endmodule // memory_map_and_pointer_select_checker

bind memory_map_and_pointer_select memory_map_and_pointer_select_checker
	u_chk (.clk, .rstn, .sfr_req, .sfr_rdata, .sfr_hit, .fetch_addr,
	.external_access_select, .fetch_external, .xdata_req, .xdata_addr,
	.xdata_valid, .int_addr, .int_mode, .int_region, .analog_digital_inputs,
	.port_digital, .analog_mux_upper, .ext_reset_req, .watchdog_req,
	.osc_watchdog_req, .reset_out_n);

/* File: ext_memory_model.sv */
/* Behavioural external program and data memory.
 Assumes the selects and the data address come registered from the decoding block. */
module ext_memory_model (
	input wire logic clk,
	input wire logic code_sel,
	input wire logic [15:0] code_addr,
	input wire logic data_sel,
	input wire logic [15:0] data_addr,
	output logic [7:0] code_byte,
	output logic [7:0] data_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	// Deselected outputs toggle so a stale byte never passes for data.
	always @(posedge clk) begin
		code_byte <= code_sel ? code_addr[7:0] ^ code_addr[15:8] : ~code_byte;
		data_byte <= data_sel ? data_addr[15:8] + data_addr[7:0] : ~data_byte;
	end
endmodule // ext_memory_model

/* File: memory_map_and_pointer_select_bench.sv */
/* Self-checking bench for the address decoding block.
 Assumes the memory model answers one cycle after an address. */
module memory_map_and_pointer_select_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] fa;
		logic sel;
		logic [7:0] ia;
		logic [1:0] im;
		logic fx;
		logic [1:0] rg;
	} row_t;
	row_t rows [6] = '{{16'h0000, 1'h0, 8'h00, 2'h0, 1'h0, 2'h0},
		{16'h1FFF, 1'h0, 8'h7F, 2'h1, 1'h0, 2'h0},
		{16'h1FFF, 1'h1, 8'h80, 2'h0, 1'h1, 2'h2},
		{16'h2000, 1'h0, 8'h80, 2'h1, 1'h1, 2'h1},
		{16'hFFFF, 1'h0, 8'hFF, 2'h2, 1'h1, 2'h1},
		{16'h2000, 1'h1, 8'hFF, 2'h0, 1'h1, 2'h2}};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	memmap_pkg::sfr_req_t sfr_req = '0;
	memmap_pkg::xdata_req_t xdata_req = '0;
	logic [15:0] fetch_addr = 16'h0000;
	logic access_sel = 1'b0;
	logic [7:0] int_addr = 8'h00;
	memmap_pkg::access_mode_t int_mode = memmap_pkg::MODE_DIRECT;
	logic [3:0] ain = 4'h0;
	logic [2:0] src = 3'h0;
	logic [7:0] sfr_rdata, code_byte, data_byte;
	logic [15:0] xdata_addr;
	logic sfr_hit, fetch_external, xdata_valid, reset_out_n;
	memmap_pkg::region_t int_region;
	logic [3:0] port_digital, analog_mux_upper;
	int errors = 0;
	int checks_done = 0;
	memory_map_and_pointer_select u_memory_map_and_pointer_select (.clk,
		.rstn, .sfr_req, .sfr_rdata, .sfr_hit, .fetch_addr,
		.external_access_select(access_sel), .fetch_external, .xdata_req,
		.xdata_addr,
		.xdata_valid, .int_addr, .int_mode, .int_region,
		.analog_digital_inputs(ain), .port_digital, .analog_mux_upper,
		.ext_reset_req(src[0]), .watchdog_req(src[1]),
		.osc_watchdog_req(src[2]), .reset_out_n);
	ext_memory_model u_ext_memory_model (.clk, .code_sel(fetch_external),
		.code_addr(fetch_addr), .data_sel(xdata_valid), .data_addr(xdata_addr),
		.code_byte, .data_byte);
	always #5 clk = ~clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic put(input memmap_pkg::sfr_req_t s,
		input memmap_pkg::xdata_req_t x);
		@(posedge clk);
		sfr_req <= s;
		xdata_req <= x;
		@(posedge clk);
		sfr_req <= '0;
		xdata_req <= '0;
		#1;
	endtask
	task automatic end_sim;
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000;
		errors++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk(16'(reset_out_n), 16'h0001);
		put({2'b01, 8'h92, 8'h00}, '0);
		chk({sfr_rdata, 7'h00, sfr_hit}, 16'h0001);
		foreach (rows[i]) begin
			@(posedge clk);
			fetch_addr <= rows[i].fa;
			access_sel <= rows[i].sel;
			int_addr <= rows[i].ia;
			int_mode <= memmap_pkg::access_mode_t'(rows[i].im);
			ain <= 4'(i + 5);
			@(posedge clk);
			#1;
			chk(16'(fetch_external), 16'(rows[i].fx));
			chk(16'(int_region), 16'(rows[i].rg));
			chk({port_digital, analog_mux_upper}, 16'({2{4'(i + 5)}}));
			@(posedge clk);
			#1;
			if (rows[i].fx)
				chk(16'(code_byte), 16'(rows[i].fa[7:0] ^ rows[i].fa[15:8]));
		end
		put({2'b10, 8'h92, 8'h5A}, '0);
		put({2'b01, 8'h92, 8'h00}, '0);
		chk(16'(sfr_rdata), 16'h005A);
		for (int i = 0; i < 8; i++) begin
			put({2'b10, 8'h92, 8'(8'hA8 + i)}, '0);
			put({2'b10, 8'h82, 8'(i * 16 + 1)}, '0);
			put({2'b10, 8'h83, 8'(8'hC0 + i)}, '0);
		end
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			sfr_req <= {2'b10, 8'h92, 8'(8'hF8 + i)};
			@(posedge clk);
			sfr_req <= '0;
			xdata_req <= 19'h60000;
			@(posedge clk);
			xdata_req <= '0;
			#1;
			chk(xdata_addr, {8'(8'hC0 + i), 8'(i * 16 + 1)});
			chk(16'(xdata_valid), 16'h0001);
			@(posedge clk);
			#1;
			chk(16'(data_byte), 16'(8'(8'hC0 + i + i * 16 + 1)));
			put({2'b01, 8'h83, 8'h00}, '0);
			chk({sfr_rdata, 7'h00, sfr_hit}, {8'(8'hC0 + i), 8'h01});
		end
		for (int u = 0; u < 2; u++) begin
			put('0, {2'b10, 1'(u), 8'h3C, 8'hC3});
			chk(xdata_addr, u ? 16'h00C3 : 16'h003C);
		end
		put({2'b10, 8'h81, 8'hFF}, '0);
		put({2'b01, 8'h81, 8'h00}, '0);
		chk({sfr_rdata, 7'h00, sfr_hit}, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			src <= 3'(1 << k);
			repeat (4) @(posedge clk);
			#1;
			chk(16'(reset_out_n), 16'h0000);
			@(posedge clk);
			src <= 3'h0;
			repeat (5) @(posedge clk);
			#1;
			chk(16'(reset_out_n), 16'h0001);
		end
		// A reset in mid-run must bring the selector back to pointer zero.
		put({2'b10, 8'h92, 8'h03}, '0);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(16'(reset_out_n), 16'h0000);
		@(posedge clk);
		rstn <= 1'b1;
		put({2'b01, 8'h92, 8'h00}, '0);
		chk({sfr_rdata, 7'h00, sfr_hit}, 16'h0001);
		put('0, 19'h60000);
		chk(xdata_addr, 16'h0000);
		chk(16'(reset_out_n), 16'h0001);
		end_sim();
	end
endmodule // memory_map_and_pointer_select_bench
